// ===== inc/cmd_decode_pkg.sv
// Constants and types shared by the command decoder, the controller model and the bench.
// Assumes a single 20 MHz clock domain.
package cmd_decode_pkg;
   localparam int ADDR_W = 14;
   localparam int BANK_W = 3;
   localparam int MR_SEL_W = 2;
   localparam int PRECHARGE_SELECT_BIT = 10;
   localparam int BURST_CHOP_BIT = 12;
   localparam int RESERVED_FIELD_BIT = 13;
   localparam int COL_W = 10;
   localparam int MR_COUNT = 4;
   localparam int SYNC_STAGES = 2;
   localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;
   localparam logic [3:0] BEATS_FOUR = 4'h4;
   localparam logic [3:0] BEATS_EIGHT = 4'h8;
   // Pin pattern {select_n, row_n, col_n, we_n}
   localparam logic [3:0] PAT_MODE_LOAD = 4'h0;
   localparam logic [3:0] PAT_REF = 4'h1;
   localparam logic [3:0] PAT_PRE = 4'h2;
   localparam logic [3:0] PAT_ACT = 4'h3;
   localparam logic [3:0] PAT_WR = 4'h4;
   localparam logic [3:0] PAT_RD = 4'h5;
   localparam logic [3:0] PAT_ZQ = 4'h6;
   localparam logic [3:0] PAT_NOP = 4'h7;
   typedef enum logic [4:0] {
      CMD_NONE, CMD_MODE_REGISTER_LOAD, CMD_REFRESH, CMD_SELF_REFRESH_ENTRY,
      CMD_SELF_REFRESH_EXIT, CMD_BANK_CLOSE, CMD_ALL_BANK_CLOSE, CMD_ROW_OPEN,
      CMD_WRITE, CMD_READ, CMD_NO_OPERATION, CMD_DESELECT, CMD_POWER_DOWN_ENTRY,
      CMD_POWER_DOWN_EXIT, CMD_IMPEDANCE_CAL_LONG, CMD_IMPEDANCE_CAL_SHORT,
      CMD_ILLEGAL
   } cmd_type;
   typedef enum logic [1:0] {ST_ACTIVE, ST_POWER_DOWN, ST_SELF_REFRESH} power_type;
endpackage

// ===== rtl/pin_sync.sv
// Two-flop synchroniser for the command and address pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);
   logic [WIDTH-1:0] meta_q;
   // Reset values are idle levels chosen by the caller through inversion
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         pin_out <= '0;
      end else begin
         meta_q <= pin_in;
         pin_out <= meta_q;
      end
   end
endmodule // pin_sync

// ===== rtl/sdram_command_decoder.sv
// Command decoder of a double-data-rate memory device.
// Assumes the controller drives pins meeting setup around the clk edge.
// Overview of operation
// - Decode strobes, clock enable, bit ten and power state at edge
// - All strobes low: load chosen mode register
// - Refresh, or self refresh on enable fall
// - Enable rise with idle pattern exits self refresh
// - Precharge: bit ten picks one or all
// - Row open in addressed bank
// - Write encoding, top address bit reserved
// - Read encoding, bit ten low keeps row
// - Bit ten high selects auto close
// - No operation registers nothing new
// - Select high means deselected, inputs ignored
// - Enable fall with idle pattern: power down
// - Enable rise with idle pattern: power up
// - Impedance calibration, bit ten long or short
// - Bank bits pick one of four registers
// - Bursts always run to completion
// - Chop bit used only when enabled
`timescale 1ns/100ps
module sdram_command_decoder (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clock_enable,
   input wire logic select_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [cmd_decode_pkg::BANK_W-1:0] bank_addr,
   input wire logic [cmd_decode_pkg::ADDR_W-1:0] addr,
   output cmd_decode_pkg::cmd_type cmd_q,
   output logic cmd_valid_q,
   output logic [cmd_decode_pkg::BANK_W-1:0] cmd_bank_q,
   output logic [cmd_decode_pkg::ADDR_W-1:0] row_addr_q,
   output logic [cmd_decode_pkg::COL_W-1:0] column_addr_q,
   output logic auto_close_q,
   output logic [3:0] burst_beats_q,
   output cmd_decode_pkg::power_type power_state_q,
   output logic [cmd_decode_pkg::ADDR_W-1:0] mode_reg_0,
   output logic [cmd_decode_pkg::ADDR_W-1:0] mode_reg_1,
   output logic [cmd_decode_pkg::ADDR_W-1:0] mode_reg_2,
   output logic [cmd_decode_pkg::ADDR_W-1:0] mode_reg_3,
   output logic burst_active_q,
   output logic per_command_select
);
   localparam int PIN_W = 5 + cmd_decode_pkg::BANK_W + cmd_decode_pkg::ADDR_W;
   // Fixed burst code in mode register 0 bits [1:0]: 0 eight, 1 per command, 2 four
   localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
   localparam logic [1:0] BL_PER_COMMAND = 2'h1;
   localparam logic [1:0] BL_FIXED_FOUR = 2'h2;

   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s;
   logic cke_s, cs_s, ras_s, cas_s, we_s;
   logic [cmd_decode_pkg::BANK_W-1:0] ba_s;
   logic [cmd_decode_pkg::ADDR_W-1:0] a_s;
   logic cke_prev_q;
   logic [cmd_decode_pkg::ADDR_W-1:0] mode_reg_q [cmd_decode_pkg::MR_COUNT];
   cmd_decode_pkg::cmd_type cmd_d;
   logic [3:0] beats_d;
   logic [3:0] beat_count_q;

   // Strobes inverted into the synchroniser so reset yields deselect
   assign pins_raw = {clock_enable, ~select_n, ~row_strobe_n, ~col_strobe_n, ~write_strobe_n,
                      bank_addr, addr};

   pin_sync #(.WIDTH(PIN_W)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_in(pins_raw),
      .pin_out(pins_s)
   );

   assign cke_s = pins_s[PIN_W-1];
   assign cs_s = ~pins_s[PIN_W-2];
   assign ras_s = ~pins_s[PIN_W-3];
   assign cas_s = ~pins_s[PIN_W-4];
   assign we_s = ~pins_s[PIN_W-5];
   assign ba_s = pins_s[cmd_decode_pkg::ADDR_W +: cmd_decode_pkg::BANK_W];
   assign a_s = pins_s[cmd_decode_pkg::ADDR_W-1:0];

   function automatic logic idle_pattern(input logic cs, input logic [3:0] pat);
      return cs | (pat == cmd_decode_pkg::PAT_NOP);
   endfunction

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cke_prev_q <= 1'b0;
      end else begin
         cke_prev_q <= cke_s;
      end
   end

   // Classification from the sampled strobes, enable pair, address bit ten and power state
   always_comb begin
      logic [3:0] pat;
      pat = {cs_s, ras_s, cas_s, we_s};
      cmd_d = cmd_decode_pkg::CMD_ILLEGAL;
      unique case ({cke_prev_q, cke_s})
         2'b11: begin
            if (cs_s) begin
               cmd_d = cmd_decode_pkg::CMD_DESELECT;
            end else begin
               unique case (pat)
                  cmd_decode_pkg::PAT_MODE_LOAD: cmd_d = cmd_decode_pkg::CMD_MODE_REGISTER_LOAD;
                  cmd_decode_pkg::PAT_REF: cmd_d = cmd_decode_pkg::CMD_REFRESH;
                  cmd_decode_pkg::PAT_PRE: cmd_d = a_s[cmd_decode_pkg::PRECHARGE_SELECT_BIT] ?
                     cmd_decode_pkg::CMD_ALL_BANK_CLOSE : cmd_decode_pkg::CMD_BANK_CLOSE;
                  cmd_decode_pkg::PAT_ACT: cmd_d = cmd_decode_pkg::CMD_ROW_OPEN;
                  cmd_decode_pkg::PAT_WR: cmd_d = cmd_decode_pkg::CMD_WRITE;
                  cmd_decode_pkg::PAT_RD: cmd_d = cmd_decode_pkg::CMD_READ;
                  cmd_decode_pkg::PAT_ZQ: cmd_d = a_s[cmd_decode_pkg::PRECHARGE_SELECT_BIT] ?
                     cmd_decode_pkg::CMD_IMPEDANCE_CAL_LONG :
                     cmd_decode_pkg::CMD_IMPEDANCE_CAL_SHORT;
                  cmd_decode_pkg::PAT_NOP: cmd_d = cmd_decode_pkg::CMD_NO_OPERATION;
                  default: cmd_d = cmd_decode_pkg::CMD_ILLEGAL;
               endcase
            end
         end
         2'b10: begin
            if (pat == cmd_decode_pkg::PAT_REF) begin
               cmd_d = cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY;
            end else if (idle_pattern(cs_s, pat)) begin
               cmd_d = cmd_decode_pkg::CMD_POWER_DOWN_ENTRY;
            end
         end
         2'b01: begin
            if (idle_pattern(cs_s, pat)) begin
               cmd_d = (power_state_q == cmd_decode_pkg::ST_SELF_REFRESH) ?
                  cmd_decode_pkg::CMD_SELF_REFRESH_EXIT :
                  cmd_decode_pkg::CMD_POWER_DOWN_EXIT;
            end
         end
         2'b00: cmd_d = cmd_decode_pkg::CMD_NONE;
      endcase
   end

   // Chop bit honoured only in per-command mode
   assign per_command_select = mode_reg_q[0][1:0] == BL_PER_COMMAND;
   always_comb begin
      if (per_command_select) begin
         beats_d = a_s[cmd_decode_pkg::BURST_CHOP_BIT] ?
            cmd_decode_pkg::BEATS_EIGHT : cmd_decode_pkg::BEATS_FOUR;
      end else if (mode_reg_q[0][1:0] == BL_FIXED_FOUR) begin
         beats_d = cmd_decode_pkg::BEATS_FOUR;
      end else begin
         beats_d = cmd_decode_pkg::BEATS_EIGHT;
      end
   end

   // cmd_q takes every decode, valid low for no-op, deselect, illegal and none; address fields hold until used
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_q <= cmd_decode_pkg::CMD_NONE;
         cmd_valid_q <= 1'b0;
         cmd_bank_q <= '0;
         row_addr_q <= '0;
         column_addr_q <= '0;
         auto_close_q <= 1'b0;
         burst_beats_q <= cmd_decode_pkg::BEATS_EIGHT;
      end else begin
         cmd_q <= cmd_d;
         cmd_valid_q <= !(cmd_d inside {cmd_decode_pkg::CMD_NONE, cmd_decode_pkg::CMD_NO_OPERATION,
                          cmd_decode_pkg::CMD_DESELECT, cmd_decode_pkg::CMD_ILLEGAL});
         if (cmd_d inside {cmd_decode_pkg::CMD_BANK_CLOSE, cmd_decode_pkg::CMD_ROW_OPEN,
                           cmd_decode_pkg::CMD_WRITE, cmd_decode_pkg::CMD_READ}) begin
            cmd_bank_q <= ba_s;
         end
         if (cmd_d == cmd_decode_pkg::CMD_ROW_OPEN) begin
            row_addr_q <= a_s;
         end
         if (cmd_d inside {cmd_decode_pkg::CMD_WRITE, cmd_decode_pkg::CMD_READ}) begin
            column_addr_q <= a_s[cmd_decode_pkg::COL_W-1:0];
            auto_close_q <= a_s[cmd_decode_pkg::PRECHARGE_SELECT_BIT];
            burst_beats_q <= beats_d;
         end
      end
   end

   // Mode registers; bank bits above the selector width are ignored
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < cmd_decode_pkg::MR_COUNT; i++) begin
            mode_reg_q[i] <= cmd_decode_pkg::MR_RESET;
         end
      end else if (cmd_d == cmd_decode_pkg::CMD_MODE_REGISTER_LOAD) begin
         mode_reg_q[ba_s[cmd_decode_pkg::MR_SEL_W-1:0]] <= a_s;
      end
   end
   assign mode_reg_0 = mode_reg_q[0];
   assign mode_reg_1 = mode_reg_q[1];
   assign mode_reg_2 = mode_reg_q[2];
   assign mode_reg_3 = mode_reg_q[3];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         power_state_q <= cmd_decode_pkg::ST_ACTIVE;
      end else begin
         unique case (cmd_d)
            cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY: power_state_q <= cmd_decode_pkg::ST_SELF_REFRESH;
            cmd_decode_pkg::CMD_POWER_DOWN_ENTRY: power_state_q <= cmd_decode_pkg::ST_POWER_DOWN;
            cmd_decode_pkg::CMD_SELF_REFRESH_EXIT,
            cmd_decode_pkg::CMD_POWER_DOWN_EXIT: power_state_q <= cmd_decode_pkg::ST_ACTIVE;
            default: power_state_q <= power_state_q;
         endcase
      end
   end

   // Burst tracker; later commands never cut it short
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         beat_count_q <= '0;
      end else if (beat_count_q != 4'h0) begin
         beat_count_q <= beat_count_q - 4'h1;
      end else if (cmd_d inside {cmd_decode_pkg::CMD_WRITE, cmd_decode_pkg::CMD_READ}) begin
         beat_count_q <= beats_d;
      end
   end
   assign burst_active_q = beat_count_q != 4'h0;

   a_mode_reg_load: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_d == cmd_decode_pkg::CMD_MODE_REGISTER_LOAD |=>
      mode_reg_q[$past(ba_s[cmd_decode_pkg::MR_SEL_W-1:0])] == $past(a_s))
      else $error("mode register not loaded");
   a_deselect_no_valid: assert property (@(posedge clk) disable iff (sys_rst)
      cke_prev_q && cke_s && cs_s |=> !cmd_valid_q) else $error("deselect produced a command");
   a_nop_no_valid: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_d == cmd_decode_pkg::CMD_NO_OPERATION |=> !cmd_valid_q) else $error("nop registered");
   a_self_refresh_enter: assert property (@(posedge clk) disable iff (sys_rst)
      cke_prev_q && !cke_s && !cs_s && !ras_s && !cas_s && we_s |=>
      power_state_q == cmd_decode_pkg::ST_SELF_REFRESH) else $error("self refresh not entered");
   a_power_down_enter: assert property (@(posedge clk) disable iff (sys_rst)
      cke_prev_q && !cke_s && cs_s |=> power_state_q == cmd_decode_pkg::ST_POWER_DOWN)
      else $error("power down not entered");
   a_power_exit_active: assert property (@(posedge clk) disable iff (sys_rst)
      !cke_prev_q && cke_s && cs_s |=> power_state_q == cmd_decode_pkg::ST_ACTIVE)
      else $error("power state not left");
   a_precharge_all_bit: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_q == cmd_decode_pkg::CMD_ALL_BANK_CLOSE |->
      $past(a_s[cmd_decode_pkg::PRECHARGE_SELECT_BIT]))
      else $error("all bank close without bit ten");
   a_auto_close_bit: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_q inside {cmd_decode_pkg::CMD_WRITE, cmd_decode_pkg::CMD_READ} |->
      auto_close_q == $past(a_s[cmd_decode_pkg::PRECHARGE_SELECT_BIT]))
      else $error("auto close mismatch");
   a_burst_runs_out: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(burst_active_q) |-> burst_active_q [*3]) else $error("burst cut short");
   a_chop_fixed_mode: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_d == cmd_decode_pkg::CMD_READ && mode_reg_q[0][1:0] == BL_FIXED_EIGHT |=>
      burst_beats_q == cmd_decode_pkg::BEATS_EIGHT) else $error("chop bit used when disabled");
   a_bank_close_one: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_d == cmd_decode_pkg::CMD_BANK_CLOSE |=> cmd_bank_q == $past(ba_s))
      else $error("bank close lost its bank");
   a_row_open_fields: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_d == cmd_decode_pkg::CMD_ROW_OPEN |=> row_addr_q == $past(a_s) &&
      cmd_bank_q == $past(ba_s)) else $error("row open fields lost");
   a_column_capture: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_d inside {cmd_decode_pkg::CMD_WRITE, cmd_decode_pkg::CMD_READ} |=>
      column_addr_q == $past(a_s[cmd_decode_pkg::COL_W-1:0]))
      else $error("column not captured");
   a_write_class: assert property (@(posedge clk) disable iff (sys_rst)
      cke_prev_q && cke_s && {cs_s, ras_s, cas_s, we_s} == cmd_decode_pkg::PAT_WR |=>
      cmd_q == cmd_decode_pkg::CMD_WRITE && cmd_valid_q) else $error("write not decoded");
   a_read_class: assert property (@(posedge clk) disable iff (sys_rst)
      cke_prev_q && cke_s && {cs_s, ras_s, cas_s, we_s} == cmd_decode_pkg::PAT_RD |=>
      cmd_q == cmd_decode_pkg::CMD_READ && cmd_valid_q) else $error("read not decoded");
   a_refresh_class: assert property (@(posedge clk) disable iff (sys_rst)
      cke_prev_q && cke_s && {cs_s, ras_s, cas_s, we_s} == cmd_decode_pkg::PAT_REF |=>
      cmd_q == cmd_decode_pkg::CMD_REFRESH && power_state_q == $past(power_state_q))
      else $error("refresh not decoded");
   a_cal_long_short: assert property (@(posedge clk) disable iff (sys_rst)
      cke_prev_q && cke_s && {cs_s, ras_s, cas_s, we_s} == cmd_decode_pkg::PAT_ZQ |=>
      cmd_q == ($past(a_s[cmd_decode_pkg::PRECHARGE_SELECT_BIT]) ?
      cmd_decode_pkg::CMD_IMPEDANCE_CAL_LONG : cmd_decode_pkg::CMD_IMPEDANCE_CAL_SHORT))
      else $error("calibration length wrong");
   a_chop_per_command: assert property (@(posedge clk) disable iff (sys_rst)
      per_command_select &&
      cmd_d inside {cmd_decode_pkg::CMD_WRITE, cmd_decode_pkg::CMD_READ} |=>
      burst_beats_q == ($past(a_s[cmd_decode_pkg::BURST_CHOP_BIT]) ?
      cmd_decode_pkg::BEATS_EIGHT : cmd_decode_pkg::BEATS_FOUR)) else $error("chop bit ignored");
   a_self_refresh_exit: assert property (@(posedge clk) disable iff (sys_rst)
      power_state_q == cmd_decode_pkg::ST_SELF_REFRESH && !cke_prev_q && cke_s &&
      (cs_s || {cs_s, ras_s, cas_s, we_s} == cmd_decode_pkg::PAT_NOP) |=>
      cmd_q == cmd_decode_pkg::CMD_SELF_REFRESH_EXIT &&
      power_state_q == cmd_decode_pkg::ST_ACTIVE) else $error("self refresh not left");
   a_power_down_exit: assert property (@(posedge clk) disable iff (sys_rst)
      power_state_q == cmd_decode_pkg::ST_POWER_DOWN && !cke_prev_q && cke_s &&
      (cs_s || {cs_s, ras_s, cas_s, we_s} == cmd_decode_pkg::PAT_NOP) |=>
      cmd_q == cmd_decode_pkg::CMD_POWER_DOWN_EXIT && cmd_valid_q)
      else $error("power down not left");
   a_enable_low_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !cke_prev_q && !cke_s |=> !cmd_valid_q && power_state_q == $past(power_state_q))
      else $error("state moved while enable low");
   a_burst_counts_down: assert property (@(posedge clk) disable iff (sys_rst)
      beat_count_q != 4'h0 |=> beat_count_q == $past(beat_count_q) - 4'h1)
      else $error("burst counter disturbed");
   c_read: cover property (@(posedge clk) cmd_q == cmd_decode_pkg::CMD_READ);
   c_write_chop: cover property (@(posedge clk)
      cmd_q == cmd_decode_pkg::CMD_WRITE && burst_beats_q == cmd_decode_pkg::BEATS_FOUR);
   c_self_refresh: cover property (@(posedge clk)
      power_state_q == cmd_decode_pkg::ST_SELF_REFRESH);
   c_cal_long: cover property (@(posedge clk) cmd_q == cmd_decode_pkg::CMD_IMPEDANCE_CAL_LONG);
   c_power_down: cover property (@(posedge clk)
      power_state_q == cmd_decode_pkg::ST_POWER_DOWN);
endmodule // sdram_command_decoder

// ===== sim/ctrl_model.sv
// Controller stand-in that drives the command, clock enable and address pins.
// Assumes the bench changes requests at the falling edge of clk.
`timescale 1ns/100ps
module ctrl_model (
   input wire logic clk,
   input wire logic req_cke,
   input wire logic [3:0] req_pat,
   input wire logic [cmd_decode_pkg::BANK_W-1:0] req_bank,
   input wire logic [cmd_decode_pkg::ADDR_W-1:0] req_addr,
   output logic clock_enable,
   output logic select_n,
   output logic row_strobe_n,
   output logic col_strobe_n,
   output logic write_strobe_n,
   output logic [cmd_decode_pkg::BANK_W-1:0] bank_addr,
   output logic [cmd_decode_pkg::ADDR_W-1:0] addr
);
   logic [cmd_decode_pkg::BANK_W-1:0] last_bank_q = 3'h0;
   logic [cmd_decode_pkg::ADDR_W-1:0] last_addr_q = 14'h0000;
   always @(posedge clk) begin
      if (!req_pat[3]) begin
         last_bank_q <= req_bank;
         last_addr_q <= req_addr;
      end
   end
   // Only listed patterns; held stable across each rising edge
   assign {select_n, row_strobe_n, col_strobe_n, write_strobe_n} = req_pat;
   assign clock_enable = req_cke;
   // Deselected: address pins show junk so a stale value cannot pass
   assign bank_addr = req_pat[3] ? ~last_bank_q : req_bank;
   assign addr = req_pat[3] ? ~last_addr_q : req_addr;
endmodule // ctrl_model

// ===== sim/testbench.sv
// Self-checking bench for the command decoder, driving pins through ctrl_model.
// Assumes three edges from pin change to registered command.
`timescale 1ns/100ps
module testbench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_cke = 1'b1;
   logic [3:0] req_pat = 4'hF;
   logic [cmd_decode_pkg::BANK_W-1:0] req_bank = 3'h0;
   logic [cmd_decode_pkg::ADDR_W-1:0] req_addr = 14'h0000;
   logic cke, sel_n, ras_n, cas_n, we_n, vld, ac, ba_on, pcs;
   logic [cmd_decode_pkg::BANK_W-1:0] ba, cbank;
   logic [cmd_decode_pkg::ADDR_W-1:0] a, row, mr0, mr1, mr2, mr3;
   logic [cmd_decode_pkg::COL_W-1:0] col;
   logic [3:0] beats;
   cmd_decode_pkg::cmd_type cmd;
   cmd_decode_pkg::power_type pst;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   typedef struct {logic [3:0] p; logic [2:0] b; logic [13:0] a;
      cmd_decode_pkg::cmd_type c; logic v;} row_type;
   row_type rows [11];
   always #25 clk = ~clk;
   ctrl_model ctrl_model_i (.clk(clk), .req_cke(req_cke), .req_pat(req_pat),
      .req_bank(req_bank), .req_addr(req_addr), .clock_enable(cke), .select_n(sel_n),
      .row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_strobe_n(we_n),
      .bank_addr(ba), .addr(a));
   sdram_command_decoder sdram_command_decoder_i (.clk(clk), .sys_rst(sys_rst),
      .clock_enable(cke), .select_n(sel_n), .row_strobe_n(ras_n), .col_strobe_n(cas_n),
      .write_strobe_n(we_n), .bank_addr(ba), .addr(a), .cmd_q(cmd), .cmd_valid_q(vld),
      .cmd_bank_q(cbank), .row_addr_q(row), .column_addr_q(col), .auto_close_q(ac),
      .burst_beats_q(beats), .power_state_q(pst), .mode_reg_0(mr0), .mode_reg_1(mr1),
      .mode_reg_2(mr2), .mode_reg_3(mr3), .burst_active_q(ba_on),
      .per_command_select(pcs));
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   // Called at a falling edge; returns at the falling edge after the decode edge
   task automatic send(input logic ck, input logic [3:0] p, input logic [2:0] b,
      input logic [13:0] ad);
      req_cke = ck;
      req_pat = p;
      req_bank = b;
      req_addr = ad;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // A hang costs one mismatch instead of a stuck run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      rows = '{'{4'h0, 3'h1, 14'h1234, cmd_decode_pkg::CMD_MODE_REGISTER_LOAD, 1'b1},
         '{4'h1, 3'h0, 14'h0000, cmd_decode_pkg::CMD_REFRESH, 1'b1},
         '{4'h2, 3'h2, 14'h0000, cmd_decode_pkg::CMD_BANK_CLOSE, 1'b1},
         '{4'h2, 3'h5, 14'h0400, cmd_decode_pkg::CMD_ALL_BANK_CLOSE, 1'b1},
         '{4'h3, 3'h3, 14'h2ABC, cmd_decode_pkg::CMD_ROW_OPEN, 1'b1},
         '{4'h4, 3'h4, 14'h0155, cmd_decode_pkg::CMD_WRITE, 1'b1},
         '{4'h5, 3'h6, 14'h0555, cmd_decode_pkg::CMD_READ, 1'b1},
         '{4'h6, 3'h0, 14'h0400, cmd_decode_pkg::CMD_IMPEDANCE_CAL_LONG, 1'b1},
         '{4'h6, 3'h7, 14'h0000, cmd_decode_pkg::CMD_IMPEDANCE_CAL_SHORT, 1'b1},
         '{4'h7, 3'h0, 14'h0000, cmd_decode_pkg::CMD_NO_OPERATION, 1'b0},
         '{4'hF, 3'h0, 14'h0000, cmd_decode_pkg::CMD_DESELECT, 1'b0}};
      repeat (8) @(posedge clk);
      @(negedge clk);
      check(cmd === cmd_decode_pkg::CMD_NONE && vld === 1'b0 && beats === 4'h8
         && pst === cmd_decode_pkg::ST_ACTIVE && mr0 === 14'h0000, "reset values");
      sys_rst = 1'b0;
      send(1'b1, 4'h7, 3'h0, 14'h0000);
      send(1'b1, 4'h7, 3'h0, 14'h0000);
      foreach (rows[i]) begin
         send(1'b1, rows[i].p, rows[i].b, rows[i].a);
         check(cmd === rows[i].c && vld === rows[i].v, "command class");
      end
      check(mr1 === 14'h1234 && mr0 === 14'h0000 && mr3 === 14'h0000, "mode reg pick");
      send(1'b1, 4'h0, 3'h2, 14'h0ABC);
      check(mr2 === 14'h0ABC && mr1 === 14'h1234, "mode reg two");
      send(1'b1, 4'h3, 3'h7, 14'h3FFF);
      check(cbank === 3'h7 && row === 14'h3FFF, "row open fields");
      send(1'b1, 4'h5, 3'h1, 14'h0000);
      check(beats === 4'h8 && ac === 1'b0 && col === 10'h000 && ba_on === 1'b1, "fixed eight");
      send(1'b1, 4'h0, 3'h0, 14'h0001);
      check(pcs === 1'b1 && mr0 === 14'h0001, "per command mode");
      send(1'b1, 4'h4, 3'h2, 14'h07FF);
      check(cmd === cmd_decode_pkg::CMD_WRITE && beats === 4'h4 && ac === 1'b1
         && col === 10'h3FF && cbank === 3'h2, "write chop four autoclose");
      send(1'b1, 4'h5, 3'h3, 14'h3400);
      check(cmd === cmd_decode_pkg::CMD_READ && beats === 4'h8 && ac === 1'b1, "read eight");
      send(1'b1, 4'h0, 3'h0, 14'h0002);
      send(1'b1, 4'h5, 3'h0, 14'h1000);
      check(beats === 4'h4 && pcs === 1'b0, "fixed four ignores chop bit");
      send(1'b1, 4'h7, 3'h0, 14'h0000);
      repeat (10) @(negedge clk);
      check(ba_on === 1'b0 && vld === 1'b0, "burst ran out");
      send(1'b0, 4'h1, 3'h0, 14'h0000);
      check(cmd === cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY
         && pst === cmd_decode_pkg::ST_SELF_REFRESH, "self refresh entry");
      send(1'b0, 4'h7, 3'h0, 14'h0000);
      check(cmd === cmd_decode_pkg::CMD_NONE && pst === cmd_decode_pkg::ST_SELF_REFRESH, "stay");
      send(1'b1, 4'hF, 3'h0, 14'h0000);
      check(cmd === cmd_decode_pkg::CMD_SELF_REFRESH_EXIT
         && pst === cmd_decode_pkg::ST_ACTIVE, "self refresh exit");
      for (int i = 0; i < 2; i++) begin
         send(1'b0, (i == 0) ? 4'h7 : 4'hF, 3'h0, 14'h0000);
         check(cmd === cmd_decode_pkg::CMD_POWER_DOWN_ENTRY
            && pst === cmd_decode_pkg::ST_POWER_DOWN, "power down entry");
         send(1'b1, (i == 0) ? 4'hF : 4'h7, 3'h0, 14'h0000);
         check(cmd === cmd_decode_pkg::CMD_POWER_DOWN_EXIT
            && pst === cmd_decode_pkg::ST_ACTIVE, "power down exit");
      end
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      check(vld === 1'b0 && mr1 === 14'h0000 && mr0 === 14'h0000 && mr2 === 14'h0000
         && cmd === cmd_decode_pkg::CMD_NONE
         && pst === cmd_decode_pkg::ST_ACTIVE, "mid-run reset");
      sys_rst = 1'b0;
      send(1'b1, 4'hF, 3'h0, 14'h0000);
      check(cmd === cmd_decode_pkg::CMD_POWER_DOWN_EXIT && vld === 1'b1, "restart exit");
      wrap_up();
   end
endmodule // testbench
